// *** design/exc_consts.svh ***
`ifndef EXC_CONSTS_SVH
`define EXC_CONSTS_SVH

// register byte addresses in the control space region
`define EXC_ADDR_TRA          32'hff000020
`define EXC_ADDR_EXCEPTION_EVENT_CODE       32'hff000024
`define EXC_ADDR_INTERRUPT_EVENT_CODE       32'hff000028
`define EXC_ALIAS_BITS        29

// field widths and reset values
`define EXC_CODE_W            12
`define EXC_INT_CODE_W        14
`define EXC_TRAP_W            8
`define EXC_EXCEPTION_EVENT_CODE_RESET      12'h000
`define EXC_INTERRUPT_EVENT_CODE_RESET      14'h0000
`define EXC_TRAP_RESET        8'h00

// status register bit positions
`define EXC_SR_BL_BIT         28
`define EXC_SR_MD_BIT         30
`define EXC_SR_RB_BIT         29
`define EXC_SR_FD_BIT         15

// vectors and offsets
`define EXC_RESET_VECTOR      32'ha0000000
`define EXC_OFS_GENERAL       32'h00000100
`define EXC_OFS_TLB_MISS      32'h00000400
`define EXC_OFS_INTERRUPT     32'h00000600

// event codes
`define EXC_CODE_POR          12'h000
`define EXC_CODE_MANUAL       12'h020
`define EXC_CODE_TLB_MULTI    12'h140
`define EXC_CODE_USER_BREAK   12'h1e0
`define EXC_CODE_ADDR_RD      12'h0e0
`define EXC_CODE_ADDR_WR      12'h100
`define EXC_CODE_MISS_RD      12'h040
`define EXC_CODE_MISS_WR      12'h060
`define EXC_CODE_PROT_RD      12'h0a0
`define EXC_CODE_PROT_WR      12'h0c0
`define EXC_CODE_ILL_GEN      12'h180
`define EXC_CODE_ILL_SLOT     12'h1a0
`define EXC_CODE_FPD_GEN      12'h800
`define EXC_CODE_FPD_SLOT     12'h820
`define EXC_CODE_TRAP         12'h160
`define EXC_CODE_FPU          12'h120
`define EXC_CODE_PAGE_WR      12'h080

// event source count and the last reset-class index
`define EXC_NUM_SRC           23
`define EXC_SRC_W             5
`define EXC_LAST_RESET_IDX    5'h04

`endif

// *** design/exc_pkg.sv ***
package exc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_ENTRY = 2'b10
  } entry_state_t;

  // event sources, listed from highest to lowest priority
  typedef enum logic [4:0] {
    SRC_POR        = 5'h00,
    SRC_DBG_RESET  = 5'h01,
    SRC_MANUAL     = 5'h02,
    SRC_ITLB_MULTI = 5'h03,
    SRC_DTLB_MULTI = 5'h04,
    SRC_BRK_BEFORE = 5'h05,
    SRC_IADDR_ERR  = 5'h06,
    SRC_ITLB_MISS  = 5'h07,
    SRC_ITLB_PROT  = 5'h08,
    SRC_ILL_GEN    = 5'h09,
    SRC_ILL_SLOT   = 5'h0a,
    SRC_FPD_GEN    = 5'h0b,
    SRC_FPD_SLOT   = 5'h0c,
    SRC_TRAP       = 5'h0d,
    SRC_DADDR_RD   = 5'h0e,
    SRC_DADDR_WR   = 5'h0f,
    SRC_DMISS_RD   = 5'h10,
    SRC_DMISS_WR   = 5'h11,
    SRC_DPROT_RD   = 5'h12,
    SRC_DPROT_WR   = 5'h13,
    SRC_FPU        = 5'h14,
    SRC_PAGE_WR    = 5'h15,
    SRC_BRK_AFTER  = 5'h16
  } src_t;

endpackage

// *** design/exc_prio_encoder.sv ***
`timescale 1ns/1ps
`default_nettype none

module exc_prio_encoder #(
  parameter int N  = 23,
  parameter int IW = 5
) (
  input  wire logic [N-1:0]  req,   // request vector, index 0 wins
  output logic               valid, // any request present
  output logic [IW-1:0]      idx    // index of the winning request
);

  logic [N:0]   below;
  logic [N-1:0] first;

  assign below[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_chain
      assign first[g]   = req[g] & ~below[g];
      assign below[g+1] = below[g] | req[g];
    end
  endgenerate

  assign valid = below[N];

  always_comb
  begin
    idx = '0;
    for (int i = 0; i < N; i++)
    begin
      if (first[i])
      begin
        idx = IW'(i);
      end
    end
  end

endmodule

`default_nettype wire

// *** design/cpu_exception_entry_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "exc_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - exception code register loaded, software writable
// - interrupt code register loaded on acceptance
// - trap loads immediate, reports code 160
// - save pc, status, r15 first
// - entry sets block, mode, bank bits
// - reset entry also clears fp disable
// - code goes to matching event register
// - return restores pc, status; r15 kept
// - resets branch to fixed reset vector
// - others branch to vector base plus offset, debug-routed user break to debug base
// - registers reachable at both address aliases
// - power-on code 000, manual code 020
// - tlb multiple hit is reset, code 140
// - tlb miss offset 400, codes 040/060
// - address errors offset 100, codes 0e0/100
// - protection violation codes 0a0/0c0
// - illegal instruction codes 180/1a0
// - fpu disabled codes 800/820
// - fpu exception 120, page write 080
// - user break 1e0 via vector or debug base
module cpu_exception_entry_unit (
  input  wire logic                     sys_clk,          // cpu clock
  input  wire logic                     rst_n,            // async reset, active low
  input  wire logic [`EXC_NUM_SRC-1:0]  exc_req,          // event requests, by src_t index
  input  wire logic                     intr_req,         // interrupt request level
  input  wire logic [13:0]              intr_code,        // code of the pending interrupt
  input  wire logic [7:0]               trap_imm,         // immediate of the trap instruction
  input  wire logic                     brk_use_debug,    // user break vectors via debug base
  input  wire logic                     rte_req,          // return instruction executes
  input  wire logic [31:0]              pc_in,            // current program counter
  input  wire logic [31:0]              sr_in,            // current status register
  input  wire logic [31:0]              r15_in,           // current general register 15
  input  wire logic [31:0]              vector_base,      // vector base register
  input  wire logic [31:0]              debug_base,       // debug base register
  input  wire logic [31:0]              reg_addr,         // register access address
  input  wire logic                     reg_rd,           // register read strobe
  input  wire logic                     reg_wr,           // register write strobe
  input  wire logic [31:0]              reg_wdata,        // register write data
  output logic [31:0]                   reg_rdata,        // register read data
  output logic                          reg_ack,          // access done pulse
  output logic                          exc_taken,        // event accepted pulse
  output logic                          intr_ack,         // interrupt accepted pulse
  output logic                          branch_valid,     // redirect pulse
  output logic [31:0]                   branch_target,    // redirect address
  output logic                          sr_load,          // status load pulse
  output logic [31:0]                   sr_value,         // status value to load
  output logic [31:0]                   saved_program_counter,  // saved pc
  output logic [31:0]                   saved_status,           // saved status
  output logic [31:0]                   saved_general_register  // saved r15
);

  //////////////////////////////////////////////////////////////////////////////
  // event tables

  function automatic logic [11:0] src_code(input logic [4:0] s);
    unique case (s)
      exc_pkg::SRC_POR,
      exc_pkg::SRC_DBG_RESET:  src_code = `EXC_CODE_POR;
      exc_pkg::SRC_MANUAL:     src_code = `EXC_CODE_MANUAL;
      exc_pkg::SRC_ITLB_MULTI,
      exc_pkg::SRC_DTLB_MULTI: src_code = `EXC_CODE_TLB_MULTI;
      exc_pkg::SRC_BRK_BEFORE,
      exc_pkg::SRC_BRK_AFTER:  src_code = `EXC_CODE_USER_BREAK;
      exc_pkg::SRC_IADDR_ERR,
      exc_pkg::SRC_DADDR_RD:   src_code = `EXC_CODE_ADDR_RD;
      exc_pkg::SRC_DADDR_WR:   src_code = `EXC_CODE_ADDR_WR;
      exc_pkg::SRC_ITLB_MISS,
      exc_pkg::SRC_DMISS_RD:   src_code = `EXC_CODE_MISS_RD;
      exc_pkg::SRC_DMISS_WR:   src_code = `EXC_CODE_MISS_WR;
      exc_pkg::SRC_ITLB_PROT,
      exc_pkg::SRC_DPROT_RD:   src_code = `EXC_CODE_PROT_RD;
      exc_pkg::SRC_DPROT_WR:   src_code = `EXC_CODE_PROT_WR;
      exc_pkg::SRC_ILL_GEN:    src_code = `EXC_CODE_ILL_GEN;
      exc_pkg::SRC_ILL_SLOT:   src_code = `EXC_CODE_ILL_SLOT;
      exc_pkg::SRC_FPD_GEN:    src_code = `EXC_CODE_FPD_GEN;
      exc_pkg::SRC_FPD_SLOT:   src_code = `EXC_CODE_FPD_SLOT;
      exc_pkg::SRC_TRAP:       src_code = `EXC_CODE_TRAP;
      exc_pkg::SRC_FPU:        src_code = `EXC_CODE_FPU;
      exc_pkg::SRC_PAGE_WR:    src_code = `EXC_CODE_PAGE_WR;
      default:                 src_code = `EXC_CODE_POR;
    endcase
  endfunction

  function automatic logic [31:0] src_offset(input logic [4:0] s);
    if (s == exc_pkg::SRC_ITLB_MISS || s == exc_pkg::SRC_DMISS_RD ||
        s == exc_pkg::SRC_DMISS_WR)
    begin
      src_offset = `EXC_OFS_TLB_MISS;
    end
    else
    begin
      src_offset = `EXC_OFS_GENERAL;
    end
  endfunction

  // top address bits are ignored so both aliases decode alike
  function automatic logic [1:0] reg_sel(input logic [31:0] a);
    if (a[28:0] == 29'(`EXC_ADDR_TRA))
    begin
      reg_sel = 2'h1;
    end
    else if (a[28:0] == 29'(`EXC_ADDR_EXCEPTION_EVENT_CODE))
    begin
      reg_sel = 2'h2;
    end
    else if (a[28:0] == 29'(`EXC_ADDR_INTERRUPT_EVENT_CODE))
    begin
      reg_sel = 2'h3;
    end
    else
    begin
      reg_sel = 2'h0;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // arbitration

  logic       src_valid;
  logic [4:0] src_idx;

  // index order encodes level first, then order within the level
  exc_prio_encoder #(
    .N  (`EXC_NUM_SRC),
    .IW (`EXC_SRC_W)
  ) u_prio (
    .req   (exc_req),
    .valid (src_valid),
    .idx   (src_idx)
  );

  //////////////////////////////////////////////////////////////////////////////
  // state

  exc_pkg::entry_state_t state_reg, state_next;
  logic [4:0]  cur_src_reg, cur_src_next;
  logic        cur_intr_reg, cur_intr_next;
  logic [13:0] intr_hold_reg, intr_hold_next;
  logic [7:0]  trap_hold_reg, trap_hold_next;
  logic [11:0] exception_event_code_reg, exception_event_code_next;
  logic [13:0] interrupt_event_code_reg, interrupt_event_code_next;
  logic [7:0]  tra_reg, tra_next;
  logic [31:0] spc_reg, spc_next, ssr_reg, ssr_next, sgr_reg, sgr_next;
  logic [31:0] rdata_reg, rdata_next, target_reg, target_next, srv_reg, srv_next;
  logic        ack_reg, ack_next, taken_reg, taken_next, iack_reg, iack_next;
  logic        br_reg, br_next, srl_reg, srl_next;
  logic        is_reset;

  assign is_reset = (cur_src_reg <= `EXC_LAST_RESET_IDX) && !cur_intr_reg;

  always_comb
  begin
    state_next     = state_reg;
    cur_src_next   = cur_src_reg;
    cur_intr_next  = cur_intr_reg;
    intr_hold_next = intr_hold_reg;
    trap_hold_next = trap_hold_reg;
    exception_event_code_next    = exception_event_code_reg;
    interrupt_event_code_next    = interrupt_event_code_reg;
    tra_next       = tra_reg;
    spc_next       = spc_reg;
    ssr_next       = ssr_reg;
    sgr_next       = sgr_reg;
    target_next    = target_reg;
    srv_next       = srv_reg;
    rdata_next     = 32'h00000000;
    ack_next       = reg_rd | reg_wr;
    taken_next     = 1'b0;
    iack_next      = 1'b0;
    br_next        = 1'b0;
    srl_next       = 1'b0;
    if (reg_rd)
    begin
      unique case (reg_sel(reg_addr))
        2'h1:    rdata_next = {24'h000000, tra_reg};
        2'h2:    rdata_next = {20'h00000, exception_event_code_reg};
        2'h3:    rdata_next = {18'h00000, interrupt_event_code_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
    if (reg_wr)
    begin
      unique case (reg_sel(reg_addr))
        2'h1:    tra_next    = reg_wdata[7:0];
        2'h2:    exception_event_code_next = reg_wdata[11:0];
        2'h3:    interrupt_event_code_next = reg_wdata[13:0];
        default: ;
      endcase
    end
    unique case (state_reg)
      exc_pkg::ST_IDLE:
      begin
        if (src_valid || intr_req)
        begin
          // state is saved before any status bit changes
          spc_next       = pc_in;
          ssr_next       = sr_in;
          sgr_next       = r15_in;
          cur_src_next   = src_idx;
          cur_intr_next  = !src_valid;
          intr_hold_next = intr_code;
          trap_hold_next = trap_imm;
          iack_next      = !src_valid;
          taken_next     = 1'b1;
          state_next     = exc_pkg::ST_ENTRY;
        end
        else if (rte_req)
        begin
          target_next = spc_reg;
          srv_next    = ssr_reg;
          br_next     = 1'b1;
          srl_next    = 1'b1;
        end
      end
      exc_pkg::ST_ENTRY:
      begin
        // hardware load beats a software write in the same cycle
        srv_next = ssr_reg;
        srv_next[`EXC_SR_BL_BIT] = 1'b1;
        srv_next[`EXC_SR_MD_BIT] = 1'b1;
        srv_next[`EXC_SR_RB_BIT] = 1'b1;
        if (is_reset)
        begin
          srv_next[`EXC_SR_FD_BIT] = 1'b0;
          target_next = `EXC_RESET_VECTOR;
        end
        else if (cur_intr_reg)
        begin
          target_next = vector_base + `EXC_OFS_INTERRUPT;
        end
        else if ((cur_src_reg == exc_pkg::SRC_BRK_BEFORE ||
                  cur_src_reg == exc_pkg::SRC_BRK_AFTER) && brk_use_debug)
        begin
          target_next = debug_base;
        end
        else
        begin
          target_next = vector_base + src_offset(cur_src_reg);
        end
        if (cur_intr_reg)
        begin
          interrupt_event_code_next = intr_hold_reg;
        end
        else
        begin
          exception_event_code_next = src_code(cur_src_reg);
        end
        if (!cur_intr_reg && cur_src_reg == exc_pkg::SRC_TRAP)
        begin
          tra_next = trap_hold_reg;
        end
        br_next    = 1'b1;
        srl_next   = 1'b1;
        state_next = exc_pkg::ST_IDLE;
      end
      default:
      begin
        state_next = exc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= exc_pkg::ST_IDLE;
      cur_src_reg   <= 5'h00;
      cur_intr_reg  <= 1'b0;
      intr_hold_reg <= 14'h0000;
      trap_hold_reg <= 8'h00;
      exception_event_code_reg    <= `EXC_EXCEPTION_EVENT_CODE_RESET;
      interrupt_event_code_reg    <= `EXC_INTERRUPT_EVENT_CODE_RESET;
      tra_reg       <= `EXC_TRAP_RESET;
      spc_reg       <= 32'h00000000;
      ssr_reg       <= 32'h00000000;
      sgr_reg       <= 32'h00000000;
      rdata_reg     <= 32'h00000000;
      target_reg    <= 32'h00000000;
      srv_reg       <= 32'h00000000;
      ack_reg       <= 1'b0;
      taken_reg     <= 1'b0;
      iack_reg      <= 1'b0;
      br_reg        <= 1'b0;
      srl_reg       <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      cur_src_reg   <= cur_src_next;
      cur_intr_reg  <= cur_intr_next;
      intr_hold_reg <= intr_hold_next;
      trap_hold_reg <= trap_hold_next;
      exception_event_code_reg    <= exception_event_code_next;
      interrupt_event_code_reg    <= interrupt_event_code_next;
      tra_reg       <= tra_next;
      spc_reg       <= spc_next;
      ssr_reg       <= ssr_next;
      sgr_reg       <= sgr_next;
      rdata_reg     <= rdata_next;
      target_reg    <= target_next;
      srv_reg       <= srv_next;
      ack_reg       <= ack_next;
      taken_reg     <= taken_next;
      iack_reg      <= iack_next;
      br_reg        <= br_next;
      srl_reg       <= srl_next;
    end
  end

  assign reg_rdata              = rdata_reg;
  assign reg_ack                = ack_reg;
  assign exc_taken              = taken_reg;
  assign intr_ack               = iack_reg;
  assign branch_valid           = br_reg;
  assign branch_target          = target_reg;
  assign sr_load                = srl_reg;
  assign sr_value               = srv_reg;
  assign saved_program_counter  = spc_reg;
  assign saved_status           = ssr_reg;
  assign saved_general_register = sgr_reg;   // never routed back to r15 on return

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic accept;
  assign accept = (state_reg == exc_pkg::ST_IDLE) && (src_valid || intr_req);

  chk_save_copy: assert property (accept |=> spc_reg == $past(pc_in) &&
    ssr_reg == $past(sr_in) && sgr_reg == $past(r15_in))
    else $error("state not saved on entry");
  chk_entry_bits: assert property (accept |=> ##1 srl_reg && srv_reg[`EXC_SR_BL_BIT] &&
    srv_reg[`EXC_SR_MD_BIT] && srv_reg[`EXC_SR_RB_BIT])
    else $error("entry status bits not set");
  chk_fd_reset: assert property (state_reg == exc_pkg::ST_ENTRY && is_reset
    |=> !srv_reg[`EXC_SR_FD_BIT])
    else $error("fp disable not cleared on reset");
  chk_reset_vec: assert property (state_reg == exc_pkg::ST_ENTRY && is_reset
    |=> br_reg && target_reg == `EXC_RESET_VECTOR)
    else $error("reset vector wrong");
  chk_base_offset: assert property (state_reg == exc_pkg::ST_ENTRY && !is_reset &&
    cur_intr_reg |=> target_reg == $past(vector_base) + `EXC_OFS_INTERRUPT)
    else $error("interrupt vector wrong");
  chk_exception_event_code_load: assert property (state_reg == exc_pkg::ST_ENTRY && !cur_intr_reg
    |=> exception_event_code_reg == src_code($past(cur_src_reg)))
    else $error("exception code not loaded");
  chk_interrupt_event_code_load: assert property (accept && !src_valid
    |=> ##1 interrupt_event_code_reg == $past(intr_code, 2))
    else $error("interrupt code not loaded");
  chk_rte_keep: assert property (state_reg == exc_pkg::ST_IDLE && !src_valid &&
    !intr_req && rte_req |=> br_reg && target_reg == $past(spc_reg) &&
    srv_reg == $past(ssr_reg) && $stable(sgr_reg))
    else $error("return did not restore");
  chk_alias_read: assert property (reg_rd && reg_sel(reg_addr) == 2'h2 &&
    state_reg == exc_pkg::ST_IDLE |=> reg_rdata == {20'h00000, $past(exception_event_code_reg)})
    else $error("event register read wrong");
  chk_prio_order: assert property (accept && exc_req[exc_pkg::SRC_POR]
    |=> cur_src_reg == exc_pkg::SRC_POR && !cur_intr_reg)
    else $error("priority not honoured");

  cov_reset_entry: cover property (state_reg == exc_pkg::ST_ENTRY && is_reset);
  cov_intr_entry: cover property (state_reg == exc_pkg::ST_ENTRY && cur_intr_reg);
  cov_trap_entry: cover property (state_reg == exc_pkg::ST_ENTRY &&
    cur_src_reg == exc_pkg::SRC_TRAP);
  cov_return: cover property (br_reg && !$past(state_reg == exc_pkg::ST_ENTRY));

endmodule

`default_nettype wire

// *** verification/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// pipeline stand-in: holds pc, status and r15, follows every redirect
module core_model (
  input  wire logic        sys_clk,       // cpu clock
  input  wire logic        rst_n,         // async reset, active low
  input  wire logic        set_en,        // bench preloads state
  input  wire logic [31:0] set_pc,        // preload pc
  input  wire logic [31:0] set_sr,        // preload status
  input  wire logic [31:0] set_r15,       // preload r15
  input  wire logic        branch_valid,  // redirect pulse
  input  wire logic [31:0] branch_target, // redirect address
  input  wire logic        sr_load,       // status load pulse
  input  wire logic [31:0] sr_value,      // status value
  output logic [31:0]      pc_in,         // current pc
  output logic [31:0]      sr_in,         // current status
  output logic [31:0]      r15_in         // current r15
);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_in  <= 32'h00000000;
      sr_in  <= 32'h00000000;
      r15_in <= 32'h00000000;
    end
    else if (set_en)
    begin
      pc_in  <= set_pc;
      sr_in  <= set_sr;
      r15_in <= set_r15;
    end
    else
    begin
      // r15 is left alone on a redirect, a return never reloads it
      if (branch_valid)
        pc_in <= branch_target;
      if (sr_load)
        sr_in <= sr_value;
    end
  end
endmodule

`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "exc_consts.svh"

module tb;
  logic         sys_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [22:0]  exc_req = 23'h000000;
  logic         intr_req = 1'b0;
  logic [13:0]  intr_code = 14'h0000;
  logic [7:0]   trap_imm = 8'h00;
  logic         brk_use_debug = 1'b0;
  logic         rte_req = 1'b0;
  logic         set_en = 1'b0;
  logic [31:0]  set_pc = 32'h0;
  logic [31:0]  set_sr = 32'h0;
  logic [31:0]  set_r15 = 32'h0;
  logic [31:0]  vector_base = 32'h80000000;
  logic [31:0]  debug_base = 32'h0;
  logic [31:0]  reg_addr = 32'h0;
  logic         reg_rd = 1'b0;
  logic         reg_wr = 1'b0;
  logic [31:0]  reg_wdata = 32'h0;
  logic [31:0]  pc_in, sr_in, r15_in, reg_rdata, branch_target, sr_value;
  logic [31:0]  saved_program_counter, saved_status, saved_general_register;
  logic         reg_ack, exc_taken, intr_ack, branch_valid, sr_load;
  logic [159:0] br_q[$];
  logic [32:0]  rd_q[$];
  logic [159:0] n;
  logic [32:0]  r;
  logic [31:0]  lp, ls, lr;
  int           error_cnt = 0;
  int           compares = 0;
  logic [11:0]  codes [23] = '{`EXC_CODE_POR, `EXC_CODE_POR, `EXC_CODE_MANUAL,
    `EXC_CODE_TLB_MULTI, `EXC_CODE_TLB_MULTI, `EXC_CODE_USER_BREAK, `EXC_CODE_ADDR_RD,
    `EXC_CODE_MISS_RD, `EXC_CODE_PROT_RD, `EXC_CODE_ILL_GEN, `EXC_CODE_ILL_SLOT,
    `EXC_CODE_FPD_GEN, `EXC_CODE_FPD_SLOT, `EXC_CODE_TRAP, `EXC_CODE_ADDR_RD,
    `EXC_CODE_ADDR_WR, `EXC_CODE_MISS_RD, `EXC_CODE_MISS_WR, `EXC_CODE_PROT_RD,
    `EXC_CODE_PROT_WR, `EXC_CODE_FPU, `EXC_CODE_PAGE_WR, `EXC_CODE_USER_BREAK};

  always #2.5 sys_clk = ~sys_clk;

  cpu_exception_entry_unit dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .exc_req(exc_req),
    .intr_req(intr_req), .intr_code(intr_code), .trap_imm(trap_imm),
    .brk_use_debug(brk_use_debug), .rte_req(rte_req), .pc_in(pc_in), .sr_in(sr_in),
    .r15_in(r15_in), .vector_base(vector_base), .debug_base(debug_base),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .exc_taken(exc_taken), .intr_ack(intr_ack),
    .branch_valid(branch_valid), .branch_target(branch_target), .sr_load(sr_load),
    .sr_value(sr_value), .saved_program_counter(saved_program_counter),
    .saved_status(saved_status), .saved_general_register(saved_general_register));

  core_model core_u (.sys_clk(sys_clk), .rst_n(rst_n), .set_en(set_en), .set_pc(set_pc),
    .set_sr(set_sr), .set_r15(set_r15), .branch_valid(branch_valid),
    .branch_target(branch_target), .sr_load(sr_load), .sr_value(sr_value),
    .pc_in(pc_in), .sr_in(sr_in), .r15_in(r15_in));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // outputs are looked at on the falling edge, where they have settled
  always @(negedge sys_clk)
  begin
    if (branch_valid === 1'b1)
    begin
      n = (br_q.size() > 0) ? br_q.pop_front() : '1;
      check(branch_target, n[159:128]);
      check(sr_value, n[127:96]);
      check({31'h0, sr_load}, 32'h1);
      check(saved_program_counter, n[95:64]);
      check(saved_status, n[63:32]);
      check(saved_general_register, n[31:0]);
    end
    if (reg_ack === 1'b1)
    begin
      r = (rd_q.size() > 0) ? rd_q.pop_front() : '1;
      if (r[32])
        check(reg_rdata, r[31:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic wr, input logic [31:0] a, d, exp);
    @(negedge sys_clk);
    rd_q.push_back({!wr, exp});
    // top three address bits are random, both aliases must decode
    reg_addr = {3'($urandom), a[28:0]};
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic wait_branch();
    int k;
    for (k = 0; k < 8 && branch_valid !== 1'b1; k++)
      @(negedge sys_clk);
    if (branch_valid !== 1'b1)
    begin
      check(32'h0, 32'h1);
      print_verdict();
    end
  endtask

  // w is the expected winner, -1 for an interrupt
  task automatic ev(input int w, input logic [22:0] req, input logic irq);
    logic [31:0] t;
    logic [31:0] s;
    @(negedge sys_clk);
    lp = $urandom;
    ls = $urandom;
    lr = $urandom;
    {set_pc, set_sr, set_r15, set_en} = {lp, ls, lr, 1'b1};
    vector_base = 32'h80000000 | ($urandom & 32'h1ffff000);
    debug_base = $urandom;
    brk_use_debug = $urandom;
    intr_code = $urandom;
    trap_imm = $urandom;
    @(negedge sys_clk);
    set_en = 1'b0;
    s = ls | (32'h1 << `EXC_SR_BL_BIT) | (32'h1 << `EXC_SR_MD_BIT) | (32'h1 << `EXC_SR_RB_BIT);
    if (w >= 0 && w <= 4)
      s[`EXC_SR_FD_BIT] = 1'b0;
    if (w >= 0 && w <= 4)
      t = `EXC_RESET_VECTOR;
    else if (w < 0)
      t = vector_base + `EXC_OFS_INTERRUPT;
    else if ((w == 5 || w == 22) && brk_use_debug)
      t = debug_base;
    else if (w == 7 || w == 16 || w == 17)
      t = vector_base + `EXC_OFS_TLB_MISS;
    else
      t = vector_base + `EXC_OFS_GENERAL;
    br_q.push_back({t, s, lp, ls, lr});
    exc_req = req;
    intr_req = irq;
    @(negedge sys_clk);
    exc_req = 23'h0;
    intr_req = 1'b0;
    check({31'h0, exc_taken}, 32'h1);
    check({31'h0, intr_ack}, {31'h0, w < 0});
    wait_branch();
    if (w < 0)
      acc(1'b0, `EXC_ADDR_INTERRUPT_EVENT_CODE, 32'h0, {18'h0, intr_code});
    else
      acc(1'b0, `EXC_ADDR_EXCEPTION_EVENT_CODE, 32'h0, {20'h0, codes[w]});
    if (w == 13)
      acc(1'b0, `EXC_ADDR_TRA, 32'h0, {24'h0, trap_imm});
    // return: pc and status from the saved copies, saved r15 untouched
    br_q.push_back({lp, ls, lp, ls, lr});
    @(negedge sys_clk);
    rte_req = 1'b1;
    @(negedge sys_clk);
    rte_req = 1'b0;
    wait_branch();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int a;
    int b;
    void'($urandom(32'h8a306d66));
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    acc(1'b0, `EXC_ADDR_EXCEPTION_EVENT_CODE, 32'h0, 32'h0);
    acc(1'b0, `EXC_ADDR_INTERRUPT_EVENT_CODE, 32'h0, 32'h0);
    acc(1'b0, `EXC_ADDR_TRA, 32'h0, 32'h0);
    acc(1'b0, 32'hff00002c, 32'h0, 32'h0);
    for (int i = 0; i < 23; i++)
      ev(i, 23'(1) << i, 1'b0);
    // two random request indices at once (possibly the same), plus a random interrupt that must lose
    repeat (12)
    begin
      a = $urandom_range(22);
      b = $urandom_range(22);
      ev((a < b) ? a : b, (23'(1) << a) | (23'(1) << b), $urandom);
    end
    repeat (3)
      ev(-1, 23'h0, 1'b1);
    acc(1'b1, `EXC_ADDR_EXCEPTION_EVENT_CODE, 32'hffffffff, 32'h0);
    acc(1'b0, `EXC_ADDR_EXCEPTION_EVENT_CODE, 32'h0, 32'h00000fff);
    acc(1'b1, `EXC_ADDR_INTERRUPT_EVENT_CODE, 32'hffffffff, 32'h0);
    acc(1'b0, `EXC_ADDR_INTERRUPT_EVENT_CODE, 32'h0, 32'h00003fff);
    acc(1'b1, `EXC_ADDR_TRA, 32'h5a5a5aa5, 32'h0);
    acc(1'b0, `EXC_ADDR_TRA, 32'h0, 32'h000000a5);
    acc(1'b1, 32'hff000030, 32'hffffffff, 32'h0);
    acc(1'b0, 32'hff000030, 32'h0, 32'h0);
    repeat (4) @(negedge sys_clk);
    check(br_q.size() + rd_q.size(), 32'h0);
    print_verdict();
  end
endmodule

`default_nettype wire
